// ### hdl/mts_map.svh
// Constants of the triggered measurement store
`ifndef MTS_MAP_SVH
`define MTS_MAP_SVH

// Capacity in records
`define MTS_DEPTH      400
// Record index width, enough for the capacity
`define MTS_IDX_W      9
// Width of each measured value
`define MTS_VAL_W      32
// System clock rate
`define MTS_CLK_HZ     40000000
// Length of the indicator dark flash on a stored trigger
`define MTS_BLINK_MS   50
`define MTS_BLINK_CYC  ((`MTS_CLK_HZ / 1000) * `MTS_BLINK_MS)

`endif

// ### hdl/mts_pkg.sv
// Types of the triggered measurement store
`include "mts_map.svh"

package mts_pkg;

  // One record of the download stream
  typedef struct packed {
    logic                  is_end;
    logic [`MTS_IDX_W-1:0] index;
    logic [`MTS_VAL_W-1:0] res;
    logic [`MTS_VAL_W-1:0] volt;
  } mts_rec_s;

  // Download sequencer
  typedef enum logic [2:0] {
    MTS_IDLE,
    MTS_BULK,
    MTS_STEP_SEND,
    MTS_STEP_WAIT,
    MTS_SEND_END
  } mts_dl_e;

endpackage : mts_pkg

// ### hdl/mts_rec_if.sv
// Record stream carrier between the store and its output buffer
`timescale 1ns/10ps
`default_nettype none

interface mts_rec_if;
  import mts_pkg::*;
  logic     valid;
  logic     ready;
  mts_rec_s data;

  modport src  (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface : mts_rec_if

`default_nettype wire

// ### hdl/mts_out_buf.sv
// Two-entry record buffer ahead of the host link
`timescale 1ns/10ps
`default_nettype none

module mts_out_buf
  import mts_pkg::*;
(
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  // Filling side
  mts_rec_if.sink   up,
  // Draining side
  output logic      o_valid,
  output mts_rec_s  o_data,
  input  wire logic i_ready
);

  logic [1:0] cnt;
  logic [1:0] next_cnt;
  mts_rec_s   slot1;
  logic       push;
  logic       pop;

  // Room while fewer than two words held, so a stall loses nothing
  assign up.ready = (cnt != 2'h2);
  assign push     = up.valid && up.ready;
  assign pop      = o_valid && i_ready;

  // Occupancy after this cycle
  always_comb begin
    next_cnt = cnt;
    if (push && !pop) begin
      next_cnt = cnt + 2'h1;
    end else if (pop && !push) begin
      next_cnt = cnt - 2'h1;
    end
  end

  // Occupancy and output valid both registered
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      cnt     <= 2'h0;
      o_valid <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      o_valid <= (next_cnt != 2'h0);
    end
  end

  // Head slot is the output word, second slot the overflow
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_data <= '0;
      slot1  <= '0;
    end else if (pop) begin
      if (cnt == 2'h2) begin
        o_data <= slot1;
        if (push) begin
          slot1 <= up.data;
        end
      end else if (push) begin
        o_data <= up.data;
      end
    end else if (push) begin
      if (cnt == 2'h0) begin
        o_data <= up.data;
      end else begin
        slot1 <= up.data;
      end
    end
  end

endmodule : mts_out_buf

`default_nettype wire

// ### hdl/mts_store.sv
// Trigger-driven measurement store with bulk and stepwise download
// How it works
// - Store control comes from host command strobes plus key, pin, range, comparator and menu inputs.
// - While enabled and below 400 records, each trigger appends one record in arrival order.
// - The enable command turns storing and the memory indicator on.
// - Key, external start or command trigger stores and flashes the LED.
// - A trigger stores the next measurement completed after it.
// - Bulk query sends every stored record and then an END record.
// - Stepwise query sends one record, then waits for the host ack.
// - Stepwise download sends END after the last record is acknowledged.
// - Records keep accumulating until cleared; reading does not empty.
// - With 400 records held, triggers add no record but still flash the LED.
// - Auto range selection is disallowed while the store is enabled.
// - Enable from off, range, comparator, clear and resets empty it.
// - The disable command stops storing and darkens the indicator.
`timescale 1ns/10ps
`default_nettype none
`include "mts_map.svh"

module mts_store
  import mts_pkg::*;
#(
  parameter int DEPTH     = `MTS_DEPTH,
  parameter int BLINK_CYC = `MTS_BLINK_CYC
)(
  // Clock and reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst_n,
  // Host command strobes, one cycle each
  input  wire logic                  i_mem_on,
  input  wire logic                  i_mem_off,
  input  wire logic                  i_mem_clear,
  input  wire logic                  i_dump_all,
  input  wire logic                  i_dump_step,
  input  wire logic                  i_ack_next,
  input  wire logic                  i_cmd_external_start_input,
  // Clearing events, one cycle each
  input  wire logic                  i_range_chg,
  input  wire logic                  i_cmp_chg,
  input  wire logic                  i_menu_reset,
  input  wire logic                  i_rst_cmd,
  input  wire logic                  i_sys_reset,
  // Triggers and trigger source
  input  wire logic                  i_key_external_start_input,
  input  wire logic                  i_ext_start_n,
  input  wire logic                  i_ext_src,
  // Measurement results
  input  wire logic                  i_meas_done,
  input  wire logic [`MTS_VAL_W-1:0] i_res_val,
  input  wire logic [`MTS_VAL_W-1:0] i_volt_val,
  // Record stream to the host link
  output logic                       o_rec_valid,
  output mts_rec_s                   o_rec,
  input  wire logic                  i_rec_ready,
  // Status
  output logic                       o_mem_led,
  output logic                       o_autorange_en,
  output logic [`MTS_IDX_W-1:0]      o_count
);

  logic [2*`MTS_VAL_W-1:0] mem [DEPTH];
  logic                    mem_on;
  logic [`MTS_IDX_W-1:0]   count;
  logic [`MTS_IDX_W-1:0]   rd;
  logic                    pend;
  logic [31:0]             blink_cnt;
  logic                    s1, s2, s3, pin_lvl;
  logic                    ext_external_start_input, external_start_input_ok, store, clr_any;
  mts_dl_e                 st;
  mts_rec_if               rec ();

  // Next record index shown to the host, counting from one
  function automatic logic [`MTS_IDX_W-1:0] idx_of(
    input logic [`MTS_IDX_W-1:0] p);
    idx_of = p + `MTS_IDX_W'(1);
  endfunction : idx_of

  // Start pin through three flops; counted only once two agree
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      s1      <= 1'b1;
      s2      <= 1'b1;
      s3      <= 1'b1;
      pin_lvl <= 1'b1;
    end else begin
      s1 <= i_ext_start_n;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        pin_lvl <= s3;
      end
    end
  end
  assign ext_external_start_input = (s2 == s3) && !s3 && pin_lvl;

  // host strobes plus range, comparator, menu reset and system reset inputs
  assign clr_any = (i_mem_on && !mem_on) || i_range_chg || i_cmp_chg
                || i_mem_clear || i_menu_reset || i_rst_cmd || i_sys_reset;
  assign external_start_input_ok = mem_on && (i_key_external_start_input || ext_external_start_input || i_cmd_external_start_input);
  assign store = pend && i_meas_done && (count < `MTS_IDX_W'(DEPTH));

  // enable turns on, disable turns off
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      mem_on <= 1'b0;
    end else if (i_mem_off) begin
      mem_on <= 1'b0;
    end else if (i_mem_on) begin
      mem_on <= 1'b1;
    end
  end

  // arm on trigger, take the next finished measurement
  // A trigger beside a clear still arms, so the new value lands after it
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      pend <= 1'b0;
    end else if (!mem_on || i_mem_off) begin
      pend <= 1'b0;
    end else if (external_start_input_ok) begin
      pend <= 1'b1;
    end else if (clr_any || i_meas_done) begin
      pend <= 1'b0;
    end
  end

  // append in order; only a clear empties
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      count <= '0;
    end else if (clr_any) begin
      count <= '0;
    end else if (store) begin
      count <= count + `MTS_IDX_W'(1);
    end
  end

  // Record array, no reset needed as count guards it
  always_ff @(posedge i_ref_clk) begin
    if (store && !clr_any) begin
      mem[count] <= {i_res_val, i_volt_val};
    end
  end

  // one dark flash per accepted trigger
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      blink_cnt <= '0;
    end else if (external_start_input_ok) begin
      blink_cnt <= 32'(BLINK_CYC);
    end else if (blink_cnt != 32'h0) begin
      blink_cnt <= blink_cnt - 32'h1;
    end
  end

  // Status flops; no auto range while enabled
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_mem_led      <= 1'b0;
      o_autorange_en <= 1'b1;
      o_count        <= '0;
    end else begin
      o_mem_led      <= mem_on && (blink_cnt == 32'h0);
      o_autorange_en <= !mem_on;
      o_count        <= count;
    end
  end

  always_comb begin
    rec.data        = '0;
    rec.data.is_end = (st == MTS_SEND_END);
    if (st != MTS_SEND_END) begin
      rec.data.index = idx_of(rd);
      {rec.data.res, rec.data.volt} = mem[rd];
    end
  end
  // A clear mid download empties the store: no stale record is offered
  assign rec.valid = (((st == MTS_BULK) || (st == MTS_STEP_SEND))
                      && (rd < count))
                  || (st == MTS_SEND_END);

  // Download sequencer; reading leaves the contents in place
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      st <= MTS_IDLE;
      rd <= '0;
    end else begin
      unique case (st)
        MTS_IDLE: begin
          rd <= '0;
          if (i_dump_all) begin
            st <= (count == '0) ? MTS_SEND_END : MTS_BULK;
          end else if (i_dump_step) begin
            st <= (count == '0) ? MTS_SEND_END : MTS_STEP_SEND;
          end
        end
        // every record back to back, then END
        MTS_BULK: begin
          if (rd >= count) begin
            st <= MTS_SEND_END;
          end else if (rec.ready) begin
            rd <= rd + `MTS_IDX_W'(1);
            if (rd + `MTS_IDX_W'(1) >= count) begin
              st <= MTS_SEND_END;
            end
          end
        end
        // one record, then hold for the ack
        MTS_STEP_SEND: begin
          if (rd >= count) begin
            st <= MTS_SEND_END;
          end else if (rec.ready) begin
            rd <= rd + `MTS_IDX_W'(1);
            st <= MTS_STEP_WAIT;
          end
        end
        // END only after the last ack; host acks each one
        MTS_STEP_WAIT: begin
          if (i_ack_next) begin
            st <= (rd >= count) ? MTS_SEND_END : MTS_STEP_SEND;
          end
        end
        MTS_SEND_END: begin
          if (rec.ready) begin
            st <= MTS_IDLE;
          end
        end
        default: st <= MTS_IDLE;
      endcase
    end
  end

  // Output buffer absorbs receiver stalls
  mts_out_buf u_buf (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .up        (rec.sink),
    .o_valid   (o_rec_valid),
    .o_data    (o_rec),
    .i_ready   (i_rec_ready)
  );

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  fill_limit_a: assert property (count <= `MTS_IDX_W'(DEPTH))
    else $error("store count above capacity");
  full_hold_a: assert property (
    (count == `MTS_IDX_W'(DEPTH)) && !clr_any |=> count == $past(count))
    else $error("full store changed");
  store_step_a: assert property (store && !clr_any |=>
    count == $past(count) + `MTS_IDX_W'(1))
    else $error("store did not append");
  enable_on_a: assert property (
    i_mem_on && !i_mem_off |=>
    mem_on ##1 (o_mem_led || $past(blink_cnt) != 32'h0))
    else $error("enable did not light indicator");
  disable_off_a: assert property (
    i_mem_off |=> !mem_on ##1 !o_mem_led)
    else $error("disable left indicator on");
  autorange_a: assert property (mem_on |=> !o_autorange_en)
    else $error("auto range allowed while storing");
  clear_empty_a: assert property (clr_any |=> count == '0)
    else $error("clear event left records");
  external_start_input_blink_a: assert property (
    external_start_input_ok |=> blink_cnt == 32'(BLINK_CYC) ##1 !o_mem_led)
    else $error("trigger did not flash indicator");
  ack_wait_a: assert property (
    st == MTS_STEP_WAIT && !i_ack_next |=> st == MTS_STEP_WAIT)
    else $error("stepwise send without ack");
  rec_index_a: assert property (
    rec.valid && rec.ready && !rec.data.is_end |=>
    rd == $past(rd) + 9'h1)
    else $error("record index out of order");

endmodule : mts_store

`default_nettype wire

// ### test/mts_host_model.sv
// Host link model: takes records, may stall, acks stepwise records
`timescale 1ns/10ps
`default_nettype none

module mts_host_model
  import mts_pkg::*;
(
  // Clock and reset
  input  wire logic     i_ref_clk,
  input  wire logic     i_rst_n,
  // Record stream from the store
  input  wire logic     i_valid,
  input  wire mts_rec_s i_rec,
  output logic          o_ready,
  // Test controls and ack back
  input  wire logic     i_slow,
  input  wire logic     i_ack_en,
  output logic          o_ack
);
  mts_rec_s   got[$];
  logic [1:0] tick;
  logic [1:0] ack_cnt;

  // Slow host refuses two cycles of every four
  assign o_ready = !i_slow || tick[1];

  // Capture records; ack sent a few cycles after each record other than END
  always_ff @(posedge i_ref_clk) begin
    o_ack <= 1'b0;
    if (!i_rst_n) begin
      tick    <= 2'h0;
      ack_cnt <= 2'h0;
    end else begin
      tick <= tick + 2'h1;
      if (i_valid && o_ready) begin
        got.push_back(i_rec);
        ack_cnt <= i_rec.is_end ? 2'h0 : 2'h3;
      end else if (ack_cnt != 2'h0 && i_ack_en) begin
        ack_cnt <= ack_cnt - 2'h1;
        o_ack   <= (ack_cnt == 2'h1);
      end
    end
  end
endmodule : mts_host_model

`default_nettype wire

// ### test/tb.sv
// Self-checking bench of the triggered measurement store
`timescale 1ns/10ps
`default_nettype none
`include "mts_map.svh"

module tb;
  import mts_pkg::*;
  logic        clk, rst_n, ext_n, ext_src, meas_done, slow, ack_en, en;
  logic [11:0] cmd;
  logic [31:0] res, volt;
  logic        rec_valid, rec_ready, led, auto, ack;
  mts_rec_s    rec;
  logic [8:0]  count;
  logic [31:0] exp[$];
  int          fail_count, num_checks;

  // Strobes: 0 on,1 off,2 bulk,3 step,4 cmd,5 key,6..11 clearing events
  mts_store #(.DEPTH(400), .BLINK_CYC(4)) dut (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_mem_on(cmd[0]),
    .i_mem_off(cmd[1]), .i_mem_clear(cmd[6]), .i_dump_all(cmd[2]),
    .i_dump_step(cmd[3]), .i_ack_next(ack), .i_cmd_external_start_input(cmd[4]),
    .i_range_chg(cmd[7]), .i_cmp_chg(cmd[8]), .i_menu_reset(cmd[9]),
    .i_rst_cmd(cmd[10]), .i_sys_reset(cmd[11]), .i_key_external_start_input(cmd[5]),
    .i_ext_start_n(ext_n), .i_ext_src(ext_src), .i_meas_done(meas_done),
    .i_res_val(res), .i_volt_val(volt), .o_rec_valid(rec_valid),
    .o_rec(rec), .i_rec_ready(rec_ready), .o_mem_led(led),
    .o_autorange_en(auto), .o_count(count));

  mts_host_model host (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_valid(rec_valid), .i_rec(rec),
    .o_ready(rec_ready), .i_slow(slow), .i_ack_en(ack_en), .o_ack(ack));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  task automatic wrap_up();
    if (fail_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [73:0] seen, input logic [73:0] want);
    num_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk

  // Sample away from the edge so its updates have landed
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : wait_n

  task automatic pulse(input int k);
    @(posedge clk);
    cmd[k] <= 1'b1;
    @(posedge clk);
    cmd <= '0;
  endtask : pulse

  // One trigger (0 cmd, 1 key, 2 pin) then one finished measurement
  task automatic store(input int k, input logic [31:0] r);
    @(posedge clk);
    ext_src <= (k == 2);
    if (k == 2) begin
      ext_n <= 1'b0;
      repeat (2) @(posedge clk);
      ext_n <= 1'b1;
    end else pulse(4 + k);
    wait_n(2);
    if (en && k != 2) chk(74'(led), 74'h0);
    repeat (3) @(posedge clk);
    res       <= r;
    volt      <= ~r;
    meas_done <= 1'b1;
    @(posedge clk);
    meas_done <= 1'b0;
    // next measurement stored, none past capacity
    if (en && exp.size() < 400) exp.push_back(r);
    wait_n(8);
    chk(74'(count), 74'(exp.size()));
    chk(74'(led), 74'(en));
  endtask : store

  // Download with a stalling host; stepwise holds its ack at first
  // The model owns its queue, so records are counted from a base mark
  task automatic dump(input logic step);
    int n;
    int base;
    base = host.got.size();
    @(posedge clk);
    slow   <= 1'b1;
    ack_en <= 1'b0;
    pulse(step ? 3 : 2);
    if (step) begin
      repeat (20) @(posedge clk);
      chk(74'(host.got.size() - base), 74'h1);
      ack_en <= 1'b1;
    end
    n = 0;
    while (n < 30000
           && (host.got.size() == base || !host.got[$].is_end)) begin
      @(posedge clk);
      n++;
    end
    if (n == 30000) begin
      fail_count++;
      wrap_up();
    end else begin
      chk(74'(host.got.size() - base), 74'(exp.size() + 1));
      for (int i = 0; i < exp.size(); i++)
        chk(host.got[base + i], {1'b0, 9'(i + 1), exp[i], ~exp[i]});
      chk(host.got[base + exp.size()], {1'b1, 73'h0});
      chk(74'(count), 74'(exp.size()));
      ack_en <= 1'b0;
    end
  endtask : dump

  task automatic sc_clear();
    for (int k = 6; k < 12; k++) begin
      store(0, 32'h100 + k);
      pulse(k);
      wait_n(2);
      chk(74'(count), 74'h0);
      exp.delete();
    end
  endtask : sc_clear

  task automatic sc_on_off();
    store(0, 32'h55);
    pulse(1);
    wait_n(2);
    en = 1'b0;
    chk(74'({led, auto}), 74'h1);
    store(1, 32'h66);
    pulse(0);
    wait_n(2);
    en = 1'b1;
    exp.delete();
    chk(74'({led, auto, count}), 74'h400);
  endtask : sc_on_off

  initial begin
    clk = 1'b0; rst_n = 1'b0; cmd = '0; ext_n = 1'b1; ext_src = 1'b0;
    meas_done = 1'b0; res = '0; volt = '0; slow = 1'b0; ack_en = 1'b0;
    en = 1'b0; fail_count = 0; num_checks = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    wait_n(1);
    chk(74'({rec_valid, led, auto, count}), 74'h200);
    store(0, 32'h11);
    pulse(0);
    wait_n(2);
    en = 1'b1;
    chk(74'({led, auto, count}), 74'h400);
    for (int i = 0; i < 402; i++) store(i % 3, 32'h1000 + i);
    dump(1'b0);
    dump(1'b1);
    sc_clear();
    sc_on_off();
    store(0, 32'h77);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    wait_n(1);
    chk(74'({led, count}), 74'h0);
    wrap_up();
  end

  // Guard against a hang anywhere
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
endmodule : tb

`default_nettype wire
